// [rtl/tach_monitor_map.vh]
// Register offsets, field positions, reset values and timing counts
// for the fan tachometer period monitor.
// Included by the monitor modules; holds definitions only.
`ifndef TACH_MONITOR_MAP_VH
`define TACH_MONITOR_MAP_VH

// APB byte offsets, one aligned word per register
`define THRESHOLD_OFFSET 12'h000
`define PERIOD_OFFSET 12'h004
`define CTRL_OFFSET 12'h008

// Control/status field positions
`define CLK_SEL_HI 6
`define CLK_SEL_LO 5
`define FILTER_OFF_BIT 4
`define IRQ_EN_BIT 3
`define OVERFLOW_BIT 2
`define OVER_THR_BIT 1
`define READY_BIT 0

// Reset values
`define THRESHOLD_RESET 8'hFF
`define PERIOD_RESET 8'h00
`define CLK_SEL_RESET 2'h1

// Timing: system clock 200 MHz, figures in their own units
`define MCLK_HZ 200000000
`define COUNT_BASE_HZ 16000
`define FILTER_CLK_HZ 32000
`define FILTER_MIN_US 750
// Cycles of the 16 KHz base tick (rounded down)
`define BASE_TICK_CYCLES (`MCLK_HZ / `COUNT_BASE_HZ)
// Cycles of the 32 KHz filter tick (rounded down)
`define FILTER_TICK_CYCLES (`MCLK_HZ / `FILTER_CLK_HZ)
// Filter ticks a pulse must stand, 750 us at 32 KHz, rounded up
`define FILTER_TICKS ((`FILTER_MIN_US * `FILTER_CLK_HZ + 999999) / 1000000)

`endif

// [rtl/tach_input_filter.v]
// Tachometer input filter: a level must stand a whole debounce time
// before it passes. Assumes its input is already synchronised to mclk.
`timescale 1ns/10ps
`include "tach_monitor_map.vh"

module tach_input_filter #(
    parameter TICK_CYCLES = `FILTER_TICK_CYCLES,
    parameter STABLE_TICKS = `FILTER_TICKS
)
(
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire clr,
    input wire raw,
    output reg filtered
);

reg [15:0] tick_cnt_reg;
reg [7:0] stable_cnt_reg;
wire tick;

assign tick = (tick_cnt_reg == TICK_CYCLES - 1);

// 32 KHz sampling tick; a differing level must persist for
// STABLE_TICKS samples, so any shorter pulse is dropped
always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        tick_cnt_reg <= 16'h0000;
        stable_cnt_reg <= 8'h00;
        filtered <= 1'b0;
    end
    else if (ce)
    begin
        tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
        if (clr)
        begin
            stable_cnt_reg <= 8'h00;
            filtered <= raw;    // Follow the line while idle
        end
        else if (raw == filtered)
            stable_cnt_reg <= 8'h00;
        else if (tick)
        begin
            if (stable_cnt_reg == STABLE_TICKS - 1)
            begin
                filtered <= raw;
                stable_cnt_reg <= 8'h00;
            end
            else
                stable_cnt_reg <= stable_cnt_reg + 8'h01;
        end
    end
end

endmodule // tach_input_filter

// [rtl/fan_tach_period_monitor.v]
// Fan tachometer period monitor with an APB register slave.
// Assumes one 200 MHz clock, tach_pulse_in and monitor_en from pins or
// another domain, and an APB master on mclk.
//
// Functional notes
// [RULE1] Threshold register is 8-bit read/write, resets to all ones.
// [RULE2] Count above threshold raises interrupt when interrupts enabled.
// [RULE3] Software should not change threshold while monitor enabled.
// [RULE4] Read-only 8-bit speed register holds latest pulse gap count.
// [RULE5] Speed register clears on reset, monitor disable, overflow set.
// [RULE6] Bits 6-5 select counter clock 16, 8, 4, 2 KHz; resets 01.
// [RULE7] Software keeps clock select unchanged while monitor enabled.
// [RULE8] Bit 4 set bypasses the input filter; reset zero applies it.
// [RULE9] Software should not toggle filter bypass while enabled.
// [RULE10] Bit 3 enables interrupt on over-threshold or overflow flag.
// [RULE11] Bit 2 overflow sets when counter passes FFh; write one clears.
// [RULE12] Bit 1 sets when loaded count exceeds threshold; write one clears.
// [RULE13] Bit 0 ready sets each rising edge after first, if not over.
// [RULE14] Ready clears on speed register read or overflow set.
// [RULE15] Qualifying edge copies counter to speed register, restarts count.
// [RULE16] No speed update while over-threshold; resume after clear and read.
// [RULE17] Input filter uses 32 KHz and rejects pulses under 750 us.
// [RULE18] Counter runs only when enabled with no overflow pending.
// [RULE19] Monitor enable is an input; low holds counter, restarts edges.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "tach_monitor_map.vh"

module fan_tach_period_monitor #(
    parameter BASE_TICK_CYCLES = `BASE_TICK_CYCLES,
    parameter FILTER_TICK_CYCLES = `FILTER_TICK_CYCLES
)
(
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire tach_pulse_in,
    input wire monitor_en,
    output reg irq
);

// Register state
reg [7:0] tach_threshold_reg;
reg [7:0] tach_period_reading_reg;
reg [7:0] pulse_gap_count_reg;
reg [1:0] clk_sel_reg;
reg filter_off_reg;
reg irq_en_reg;
reg overflow_reg;
reg over_thr_reg;
reg ready_reg;
reg read_since_clear_reg;   // Speed read seen after over-threshold clear
reg seen_first_reg;         // First edge after activation already seen
reg tach_prev_reg;
reg [15:0] base_cnt_reg;
reg [2:0] div_cnt_reg;

// Two-flop synchronisers for pin-side inputs
reg tach_meta_reg;
reg tach_sync_reg;
reg en_meta_reg;
reg en_sync_reg;

wire tach_filtered;
wire tach_level;
wire rise;
wire base_tick;
wire count_tick;
wire setup_ok;
wire wr_en;
wire rd_en;
wire [7:0] ctrl_view;
wire w1c_ovf;
wire w1c_thr;
wire thr_wr;
wire period_rd;
wire load_ok;
wire ovf_event;
wire thr_event;

// Address match helper, used by both read and write decode
function addr_is;
    input [11:0] addr;
    input [11:0] offset;
    begin
        addr_is = (addr == offset);
    end
endfunction

// Synchronise the tach line and the enable from outside
always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        tach_meta_reg <= 1'b0;
        tach_sync_reg <= 1'b0;
        en_meta_reg <= 1'b0;
        en_sync_reg <= 1'b0;
    end
    else if (ce)
    begin
        tach_meta_reg <= tach_pulse_in;
        tach_sync_reg <= tach_meta_reg;
        en_meta_reg <= monitor_en;
        en_sync_reg <= en_meta_reg;
    end
end

// [RULE17] 32 KHz glitch filter
tach_input_filter #(
    .TICK_CYCLES(FILTER_TICK_CYCLES)
) u_filter (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .clr(~en_sync_reg),
    .raw(tach_sync_reg),
    .filtered(tach_filtered)
);

// [RULE8] Filter bypass select
assign tach_level = filter_off_reg ? tach_sync_reg : tach_filtered;
assign rise = tach_level & ~tach_prev_reg & en_sync_reg;

// [RULE6] 16 KHz base tick divided by 1, 2, 4 or 8
assign base_tick = (base_cnt_reg == BASE_TICK_CYCLES - 1);
assign count_tick = base_tick &
    ((clk_sel_reg == 2'h0) ? 1'b1 :
     (clk_sel_reg == 2'h1) ? (div_cnt_reg[0] == 1'b1) :
     (clk_sel_reg == 2'h2) ? (div_cnt_reg[1:0] == 2'h3) :
     (div_cnt_reg == 3'h7));

// APB decode: one access phase, answered after one wait cycle
assign setup_ok = psel & penable & ~pready;
assign wr_en = setup_ok & pwrite;
assign rd_en = setup_ok & ~pwrite;
assign thr_wr = wr_en & addr_is(paddr, `THRESHOLD_OFFSET);
assign period_rd = rd_en & addr_is(paddr, `PERIOD_OFFSET);
assign w1c_ovf = wr_en & addr_is(paddr, `CTRL_OFFSET) &
    pwdata[`OVERFLOW_BIT];
assign w1c_thr = wr_en & addr_is(paddr, `CTRL_OFFSET) &
    pwdata[`OVER_THR_BIT];

assign ctrl_view = {1'b0, clk_sel_reg, filter_off_reg, irq_en_reg,
    overflow_reg, over_thr_reg, ready_reg};

// [RULE16] Loads blocked while over-threshold or awaiting the read
assign load_ok = ~over_thr_reg & read_since_clear_reg;
// [RULE11] Counter passing FFh
assign ovf_event = en_sync_reg & ~overflow_reg & count_tick &
    (pulse_gap_count_reg == 8'hFF) & ~(rise & seen_first_reg);
// [RULE12] Loaded count above threshold
assign thr_event = rise & seen_first_reg & load_ok & ~overflow_reg &
    (pulse_gap_count_reg > tach_threshold_reg);

// Clock dividers
always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        base_cnt_reg <= 16'h0000;
        div_cnt_reg <= 3'h0;
    end
    else if (ce)
    begin
        if (base_tick)
        begin
            base_cnt_reg <= 16'h0000;
            div_cnt_reg <= div_cnt_reg + 3'h1;
        end
        else
            base_cnt_reg <= base_cnt_reg + 16'h0001;
    end
end

// Configuration registers
always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        // [RULE1] Threshold resets to all ones
        tach_threshold_reg <= `THRESHOLD_RESET;
        clk_sel_reg <= `CLK_SEL_RESET;
        filter_off_reg <= 1'b0;
        irq_en_reg <= 1'b0;
    end
    else if (ce)
    begin
        if (thr_wr)
            tach_threshold_reg <= pwdata[7:0];
        if (wr_en && addr_is(paddr, `CTRL_OFFSET))
        begin
            // [RULE6] Clock select written by software
            clk_sel_reg <= pwdata[`CLK_SEL_HI:`CLK_SEL_LO];
            // [RULE8] Filter bypass bit
            filter_off_reg <= pwdata[`FILTER_OFF_BIT];
            // [RULE10] Interrupt gate bit
            irq_en_reg <= pwdata[`IRQ_EN_BIT];
        end
    end
end

// Measurement core: counter, speed register and status flags
always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        pulse_gap_count_reg <= 8'h00;
        tach_period_reading_reg <= `PERIOD_RESET;
        overflow_reg <= 1'b0;
        over_thr_reg <= 1'b0;
        ready_reg <= 1'b0;
        read_since_clear_reg <= 1'b1;
        seen_first_reg <= 1'b0;
        tach_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
        tach_prev_reg <= tach_level;
        if (!en_sync_reg)
        begin
            // [RULE19] Disabled: hold count at zero, forget edges
            pulse_gap_count_reg <= 8'h00;
            // [RULE5] Speed register cleared while disabled
            tach_period_reading_reg <= 8'h00;
            seen_first_reg <= 1'b0;
            ready_reg <= period_rd ? 1'b0 : ready_reg;
        end
        else if (ovf_event)
        begin
            // [RULE5] Overflow clears the speed reading
            tach_period_reading_reg <= 8'h00;
            pulse_gap_count_reg <= 8'h00;
            // [RULE14] Overflow drops ready
            ready_reg <= 1'b0;
        end
        else if (rise && !overflow_reg)
        begin
            seen_first_reg <= 1'b1;
            if (seen_first_reg && load_ok)
            begin
                // [RULE15] Capture gap and restart counting
                tach_period_reading_reg <= pulse_gap_count_reg;
                pulse_gap_count_reg <= 8'h00;
                // [RULE13] New reading ready
                ready_reg <= 1'b1;
            end
            else
            begin
                pulse_gap_count_reg <= 8'h00;
                ready_reg <= period_rd ? 1'b0 : ready_reg;
            end
        end
        else
        begin
            // [RULE18] Count only while enabled and no overflow pending
            if (count_tick && !overflow_reg)
                pulse_gap_count_reg <= pulse_gap_count_reg + 8'h01;
            // [RULE14] Speed register read clears ready
            if (period_rd)
                ready_reg <= 1'b0;
        end

        // [RULE11] Set beats write-one-clear in the same cycle
        if (ovf_event)
            overflow_reg <= 1'b1;
        else if (w1c_ovf)
            overflow_reg <= 1'b0;

        // [RULE12] Set beats write-one-clear in the same cycle
        if (thr_event)
            over_thr_reg <= 1'b1;
        else if (w1c_thr)
            over_thr_reg <= 1'b0;

        // [RULE16] After the clear, wait for a speed read
        if (thr_event)
            read_since_clear_reg <= 1'b0;
        else if (period_rd && !over_thr_reg)
            read_since_clear_reg <= 1'b1;
    end
end

// APB response: one wait cycle, read data and error registered
always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
    else if (ce)
    begin
        pready <= setup_ok;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        if (setup_ok)
        begin
            if (addr_is(paddr, `THRESHOLD_OFFSET))
                prdata <= {24'h000000, tach_threshold_reg};
            // [RULE4] Speed reading is read-only
            else if (addr_is(paddr, `PERIOD_OFFSET))
                prdata <= {24'h000000, tach_period_reading_reg};
            else if (addr_is(paddr, `CTRL_OFFSET))
                prdata <= {24'h000000, ctrl_view};
            else
                pslverr <= 1'b1;    // Unmapped address
            // Writes return zero data; only reads carry a value
            if (pwrite)
                prdata <= 32'h00000000;
        end
    end
end

// Interrupt output, registered for a clean level
always @(posedge mclk or posedge rst)
begin
    if (rst)
        irq <= 1'b0;
    else if (ce)
        // [RULE2] [RULE10] Gated by the enable bit
        irq <= irq_en_reg & (over_thr_reg | overflow_reg);
end

endmodule // fan_tach_period_monitor

// [test/tach_fan_model.sv]
// Fan tachometer pulse source for the monitor bench.
// Assumes the bench asks for one pulse at a time.
`timescale 1ns/10ps
module tach_fan_model (
    input wire mclk,
    input wire fire,
    input wire [7:0] width,
    output reg tach
);
    reg [7:0] left;
    initial tach = 1'b0;
    initial left = 8'h00;
    // Pulse stands width cycles, then falls back to idle low
    always @(posedge mclk)
    begin
        if (fire)
            left <= width;
        else if (left != 8'h00)
            left <= left - 8'h01;
        tach <= fire || left > 8'h01;
    end
endmodule // tach_fan_model

// [test/tach_mon_assertions.sv]
// Register port and interrupt checker for the tach monitor.
// Assumes ce is held high by the bench.
`timescale 1ns/10ps
`include "tach_monitor_map.vh"
module tach_mon_chk (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq
);
    wire ctl;
    wire hit;
    // Decode of the three register words
    assign ctl = paddr == `CTRL_OFFSET;
    assign hit = paddr == `THRESHOLD_OFFSET || paddr == `PERIOD_OFFSET
        || ctl;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wait_one_a:
        assert property (psel && penable && !pready && ce |=> pready)
        else $error("late ready");
    ready_pulse_a:
        assert property (pready && ce |=> !pready)
        else $error("ready too long");
    err_decode_a:
        assert property (pready |-> pslverr == !hit)
        else $error("bad error flag");
    idle_zero_a:
        assert property (!pready || pwrite |-> prdata == 32'h00000000)
        else $error("data outside read");
    upper_zero_a:
        assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper bits set");
    rsvd_bit_a:
        assert property (pready && ctl |-> !prdata[7])
        else $error("reserved bit set");
    irq_reset_a:
        assert property ($fell(rst) |-> !irq ##1 !irq)
        else $error("irq after reset");
    irq_mask_a:
        assert property (pready && pwrite && ctl && !pwdata[3]
            |=> ##1 !irq)
        else $error("irq not masked");
    c_irq: cover property ($rose(irq));
    c_err: cover property (pready && pslverr);
    c_rd: cover property (pready && !pwrite && paddr == `PERIOD_OFFSET);
endmodule // tach_mon_chk

bind fan_tach_period_monitor tach_mon_chk u_chk (.mclk(mclk), .rst(rst),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

// [test/fan_tach_period_monitor_tb.sv]
// Self-checking bench for the fan tach period monitor.
// Assumes short tick parameters and a pulse model on the tach pin.
`timescale 1ns/10ps
`include "tach_monitor_map.vh"
module fan_tach_period_monitor_tb;
    localparam THR = `THRESHOLD_OFFSET;
    localparam PER = `PERIOD_OFFSET;
    localparam CTRL = `CTRL_OFFSET;
    reg mclk, rst, psel, penable, pwrite, monitor_en, fire, rerr;
    reg [11:0] paddr;
    reg [7:0] pw;
    reg [31:0] pwdata, rdat;
    wire [31:0] prdata;
    wire pready, pslverr, irq, tach;
    integer fails, cmp_count;

    fan_tach_period_monitor #(.BASE_TICK_CYCLES(4),
        .FILTER_TICK_CYCLES(2)) u_dut (.mclk(mclk), .rst(rst),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tach_pulse_in(tach),
        .monitor_en(monitor_en), .irq(irq));
    tach_fan_model u_fan (.mclk(mclk), .fire(fire), .width(pw),
        .tach(tach));

    // 200 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task cyc(input integer n);
        repeat (n) @(posedge mclk);
    endtask

    // One APB transfer; holds everything until pready is sampled
    task apb(input [11:0] a, input w, input [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("unexpected %0s exp %h got %h", nm, e, g);
        end
    endtask

    // Tick phase against the pulse allows one count either way
    task near(input [63:0] nm, input [7:0] e, input [7:0] g);
        cmp_count = cmp_count + 1;
        if (!(g === e || g === e + 8'h01 || g === e - 8'h01))
        begin
            fails = fails + 1;
            $display("unexpected %0s exp %h got %h", nm, e, g);
        end
    endtask

    task rd(input [11:0] a, input [7:0] e, input [63:0] nm);
        apb(a, 1'b0, 8'h00);
        chk(nm, {24'h000000, e}, rdat);
    endtask

    task pulse;
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
    endtask

    task t_reset;
        rd(THR, 8'hFF, "thr");
        rd(PER, 8'h00, "per");
        rd(CTRL, 8'h20, "ctrl");
        apb(12'h00C, 1'b0, 8'h00);
        chk("err", 32'h1, rerr);
        apb(THR, 1'b1, 8'h5A);
        rd(THR, 8'h5A, "thrrw");
        apb(PER, 1'b1, 8'h33);
        rd(PER, 8'h00, "perro");
        apb(CTRL, 1'b1, 8'hFF);
        rd(CTRL, 8'h78, "ctrlrw");
        apb(THR, 1'b1, 8'hFF);
        $display("t_reset done");
    endtask

    // Every clock select; config only changes while disabled
    task t_sel;
        integer s;
        for (s = 0; s < 4; s = s + 1)
        begin
            apb(CTRL, 1'b1, {1'b0, s[1:0], 5'h10});
            monitor_en <= 1'b1;
            cyc(8);
            pulse;
            rd(CTRL, {1'b0, s[1:0], 5'h10}, "first");
            cyc(20 * (4 << s) - 4);
            pulse;
            cyc(10);
            rd(CTRL, {1'b0, s[1:0], 5'h11}, "ready");
            apb(PER, 1'b0, 8'h00);
            near("speed", 8'h14, rdat[7:0]);
            rd(CTRL, {1'b0, s[1:0], 5'h10}, "rdclr");
            monitor_en <= 1'b0;
            cyc(6);
        end
        rd(PER, 8'h00, "disclr");
        $display("t_sel done");
    endtask

    task t_over;
        apb(THR, 1'b1, 8'h08);
        apb(CTRL, 1'b1, 8'h18);
        monitor_en <= 1'b1;
        cyc(8);
        pulse;
        cyc(40);
        pulse;
        cyc(10);
        rd(CTRL, 8'h1B, "over");
        chk("irq", 32'h1, irq);
        apb(CTRL, 1'b1, 8'h10);
        cyc(3);
        chk("irqmask", 32'h0, irq);
        pulse;
        apb(CTRL, 1'b1, 8'h12);
        apb(PER, 1'b0, 8'h00);
        near("hold", 8'h0A, rdat[7:0]);
        pulse;
        cyc(10);
        apb(CTRL, 1'b0, 8'h00);
        chk("resume", 32'h1, rdat[0]);
        monitor_en <= 1'b0;
        cyc(6);
        $display("t_over done");
    endtask

    // Overflow, write-zero keep, write-one clear, then counting resumes
    task t_ovf;
        apb(CTRL, 1'b1, 8'h1E);
        monitor_en <= 1'b1;
        cyc(8);
        pulse;
        cyc(1100);
        rd(CTRL, 8'h1C, "ovf");
        chk("irqovf", 32'h1, irq);
        rd(PER, 8'h00, "ovfclr");
        apb(CTRL, 1'b1, 8'h18);
        rd(CTRL, 8'h1C, "w0keep");
        apb(CTRL, 1'b1, 8'h1C);
        cyc(3);
        rd(CTRL, 8'h18, "w1clr");
        chk("irqclr", 32'h0, irq);
        pulse;
        cyc(10);
        rd(CTRL, 8'h19, "resume2");
        apb(PER, 1'b0, 8'h00);
        near("ovfres", 8'h03, rdat[7:0]);
        monitor_en <= 1'b0;
        cyc(6);
        $display("t_ovf done");
    endtask

    // Filter on: a short glitch is dropped, long pulses pass;
    // pulses are spaced so the filter has settled low in between
    task t_filt;
        apb(THR, 1'b1, 8'hFF);
        apb(CTRL, 1'b1, 8'h00);
        monitor_en <= 1'b1;
        cyc(8);
        pw <= 8'h50;
        pulse;
        cyc(150);
        pw <= 8'h04;
        pulse;
        cyc(100);
        rd(CTRL, 8'h00, "glitch");
        pw <= 8'h50;
        pulse;
        cyc(100);
        rd(CTRL, 8'h01, "filtok");
        apb(PER, 1'b0, 8'h00);
        near("fspeed", 8'h40, rdat[7:0]);
        monitor_en <= 1'b0;
        cyc(6);
        $display("t_filt done");
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Reset, then the scenarios in order
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        monitor_en = 1'b0;
        fire = 1'b0;
        pw = 8'h04;
        fails = 0;
        cmp_count = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset;
        t_sel;
        t_over;
        t_ovf;
        t_filt;
        test_done;
    end

    // Watchdog, well past the expected run length
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails = fails + 1;
        test_done;
    end
endmodule // fan_tach_period_monitor_tb
